//--- sarc_defs.svh
/*
  Constants of the stereo rate converter: widths, offsets, reset values, timing.
  Assumes inclusion by bare name from the package and the design files.
*/
// Summary of operation
// - input words of 4 to 16 bits per channel are accepted
// - short input words are zero filled in the low bits
// - each output sample is 24 bits; the receiver may take fewer
// - coefficients are 22 bits wide, the accumulator 27 bits wide
// - overall gain through the converter is one, to within 2 output lsbs
// - each port may be left justified, msb at the edge or one bit later
// - in right justified format the msb starts 16 bit clocks after the edge
// - each port may align its word to a word clock rising edge instead
// - two static mode pins per port choose its format
// - each port may handle data on the rising bit clock edge
// - the rate ratio is measured without any configuration
// - frame clocks may have any frequency and phase relation
// - coefficients chosen from the filtered ratio feed an fir convolution
// - full bandwidth is kept when the output rate is not below the input rate
// - when output rate is lower the cutoff drops smoothly
// - a pin selects tracking that settles in 800 ms or 200 ms
`ifndef SARC_DEFS_SVH
`define SARC_DEFS_SVH
`define SARC_IN_W           16
`define SARC_IN_MIN_W       4
`define SARC_OUT_W          24
`define SARC_COEF_W         22
`define SARC_ACC_W          27
`define SARC_FRAC_W         20
`define SARC_PROD_SHIFT     12
`define SARC_RJ_START       16
`define SARC_PER_W          16
`define SARC_BLEND_MAX      4'h8
`define SARC_SLOW_SHIFT     4
`define SARC_FAST_SHIFT     2
`define SARC_SLOW_SETTLE_MS 800
`define SARC_FAST_SETTLE_MS 200
`define SARC_CLK_KHZ        100000
`define SARC_ADR_CTRL       8'h00
`define SARC_ADR_STAT       8'h04
`define SARC_ADR_IPER       8'h08
`define SARC_ADR_OPER       8'h0C
`define SARC_CTRL_LEN_RST   5'h10
`define SARC_STAT_LOCK      0
`define SARC_STAT_DOWN      1
`define SARC_STAT_BLEND     4
`endif

//--- sarc_pkg.sv
/*
  Types shared by the rate converter modules.
  Assumes sarc_defs.svh is on the include path.
*/
package sarc_pkg;
  `include "sarc_defs.svh"

  typedef enum logic [1:0] {
    SARC_LJ = 2'h0, SARC_LJ_DLY = 2'h1, SARC_RJ = 2'h2, SARC_WCLK = 2'h3
  } sarc_fmt_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0, ST_DIV = 2'h1, ST_MAC = 2'h3, ST_DONE = 2'h2
  } sarc_state_t;

  typedef struct packed {
    logic [`SARC_IN_W-1:0] data;
    logic                  left;
  } sarc_word_t;

  typedef struct packed {
    logic [`SARC_OUT_W-1:0] left;
    logic [`SARC_OUT_W-1:0] right;
  } sarc_frame_t;

  typedef struct packed {
    sarc_fmt_t fmt;
    logic      rise;
  } sarc_port_cfg_t;

  typedef logic signed [`SARC_COEF_W-1:0] sarc_coef_t;

  // bit slot of the msb after the frame or word clock event
  function automatic logic [5:0] sarc_start(input sarc_fmt_t f);
    case (f)
      SARC_LJ_DLY: sarc_start = 6'h01;
      SARC_RJ:     sarc_start = 6'(`SARC_RJ_START);
      default:     sarc_start = 6'h00;
    endcase
  endfunction : sarc_start
endpackage : sarc_pkg

//--- sarc_serial_rx.sv
/*
  Serial input port receiver on the input bit clock.
  Assumes frame, word clock and data change on the far end's launch edge;
  control levels from the core domain are static and are resynchronised here.
*/
`timescale 1ns/1ps
`include "sarc_defs.svh"
module sarc_serial_rx
  import sarc_pkg::*;
(
  // link clock and core-domain controls
  input  wire logic           bit_clk,
  input  wire logic           rst_n,
  input  wire logic           ce,
  input  wire logic [4:0]     word_len,
  // serial pins and format pins
  input  wire logic           frame_clk,
  input  wire logic           word_clk,
  input  wire logic           sdata,
  input  wire sarc_port_cfg_t cfg,
  // received word, held until the next toggle
  output sarc_word_t          word,
  output logic                word_tog
);
  logic [1:0]     rst_s;
  logic [1:0]     ce_s;
  logic [2:0]     cfg_s1;
  logic [2:0]     cfg_s2;
  logic [4:0]     len_s1;
  logic [4:0]     len_s2;
  logic           dat_f;
  logic           frm_f;
  logic           wck_f;
  logic           frm_q_r;
  logic           wck_q_r;
  logic [5:0]     pos_r;
  logic [15:0]    shf_r;
  sarc_word_t     word_r;
  logic           tog_r;

  always_ff @(posedge bit_clk) begin
    rst_s  <= {rst_s[0], rst_n};
    ce_s   <= {ce_s[0], ce};
    cfg_s1 <= cfg;
    cfg_s2 <= cfg_s1;
    len_s1 <= word_len;
    len_s2 <= len_s1;
  end

  // falling-edge samples serve the default edge
  always_ff @(negedge bit_clk) begin
    dat_f <= sdata;
    frm_f <= frame_clk;
    wck_f <= word_clk;
  end

  wire sarc_port_cfg_t cfg_q   = sarc_port_cfg_t'(cfg_s2);
  wire logic           dat_n   = cfg_q.rise ? sdata : dat_f;
  wire logic           frm_n   = cfg_q.rise ? frame_clk : frm_f;
  wire logic           wck_n   = cfg_q.rise ? word_clk : wck_f;
  wire logic           restart = (cfg_q.fmt == SARC_WCLK) ? (wck_n & ~wck_q_r) : (frm_n ^ frm_q_r);
  wire logic [5:0]     pos_nxt = restart ? 6'h00 : ((pos_r == 6'h3F) ? pos_r : pos_r + 6'h01);
  wire logic [4:0]     len_eff = (len_s2 < 5'(`SARC_IN_MIN_W)) ? 5'(`SARC_IN_MIN_W) :
                                 ((len_s2 > 5'(`SARC_IN_W)) ? 5'(`SARC_IN_W) : len_s2);
  wire logic [5:0]     start   = sarc_start(cfg_q.fmt);
  wire logic [5:0]     k       = pos_nxt - start;
  wire logic           in_word = (pos_nxt >= start) && (k < {1'b0, len_eff});
  wire logic [15:0]    base    = restart ? 16'h0000 : shf_r;
  wire logic [15:0]    shf_nxt = in_word ? (base | ({dat_n, 15'h0000} >> k)) : base;
  wire logic           last    = in_word && (k == ({1'b0, len_eff} - 6'h01));

  always_ff @(posedge bit_clk) begin
    if (!rst_s[1]) begin
      frm_q_r <= 1'b0;
      wck_q_r <= 1'b0;
      pos_r   <= 6'h3F;
      shf_r   <= 16'h0000;
      word_r  <= '0;
      tog_r   <= 1'b0;
    end else if (ce_s[1]) begin
      frm_q_r <= frm_n;
      wck_q_r <= wck_n;
      pos_r   <= pos_nxt;
      shf_r   <= shf_nxt;
      if (last) begin
        word_r <= '{data: shf_nxt, left: frm_n};
        tog_r  <= ~tog_r;
      end
    end
  end

  assign word     = word_r;
  assign word_tog = tog_r;

  default clocking cb_rx @(posedge bit_clk); endclocking
  default disable iff (!rst_s[1] || !ce_s[1]);

  property p_pad;
    $changed(tog_r) |-> (16'(word_r.data << $past(len_eff)) == 16'h0000);
  endproperty
  a_pad: assert property (p_pad) else $error("input word low bits not zero filled");

  property p_msb;
    (in_word && (k == 6'h00)) |=> (shf_r[15] == $past(dat_n));
  endproperty
  a_msb: assert property (p_msb) else $error("input msb not taken on chosen edge");
endmodule : sarc_serial_rx

//--- sarc_rate_converter.sv
/*
  Stereo asynchronous rate converter: input receiver on its own bit clock,
  ratio tracking, coefficient choice, fir convolution, serial output port and
  a classic Wishbone register slave.
  Assumes the output bit clock is at most a quarter of CLK; all pins are
  asynchronous to CLK apart from the Wishbone signals, RST_N and CE.
*/
`timescale 1ns/1ps
`include "sarc_defs.svh"
module sarc_rate_converter
  import sarc_pkg::*;
#(
  parameter int SLOW_SETTLE_CYC = `SARC_SLOW_SETTLE_MS * `SARC_CLK_KHZ,
  parameter int FAST_SETTLE_CYC = `SARC_FAST_SETTLE_MS * `SARC_CLK_KHZ,
  parameter int PER_W           = `SARC_PER_W
) (
  // core clock, reset, enable
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        CE,
  // wishbone slave
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic        WB_WE_I,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  output logic             WB_ACK_O,
  // serial input port
  input  wire logic        IN_BIT_CLK,
  input  wire logic        IN_FRAME_CLK,
  input  wire logic        IN_WORD_CLK,
  input  wire logic        IN_DATA,
  input  wire logic [1:0]  IN_MODE,
  input  wire logic        IN_RISE,
  // serial output port
  input  wire logic        OUT_BIT_CLK,
  input  wire logic        OUT_FRAME_CLK,
  input  wire logic        OUT_WORD_CLK,
  input  wire logic [1:0]  OUT_MODE,
  input  wire logic        OUT_RISE,
  output logic             OUT_DATA,
  // ratio tracking speed
  input  wire logic        SETTLE_FAST
);
  localparam int         FW  = `SARC_FRAC_W;
  localparam sarc_coef_t ONE = sarc_coef_t'(1 << FW);
  localparam int         OW  = `SARC_OUT_W;

  function automatic logic [PER_W+3:0] iir_step(input logic [PER_W+3:0] acc,
                                                input logic [PER_W-1:0] raw, input logic fast);
    logic signed [PER_W+4:0] d;
    d = $signed({1'b0, raw, 4'h0}) - $signed({1'b0, acc});
    d = fast ? (d >>> `SARC_FAST_SHIFT) : (d >>> `SARC_SLOW_SHIFT);
    iir_step = acc + d[PER_W+3:0];
  endfunction : iir_step

  // a period far from its filtered value restarts acquisition
  function automatic logic far_off(input logic [PER_W-1:0] raw, input logic [PER_W+3:0] acc);
    logic [PER_W-1:0] f;
    f = acc[PER_W+3:4];
    far_off = ((raw > f) ? raw - f : f - raw) > (raw >> 3);
  endfunction : far_off

  function automatic logic signed [`SARC_ACC_W-1:0] mac_term(input logic signed [15:0] x,
                                                            input sarc_coef_t c);
    logic signed [37:0] pr;
    pr = x * c;
    mac_term = (`SARC_ACC_W)'(pr >>> `SARC_PROD_SHIFT);
  endfunction : mac_term

  function automatic logic [OW-1:0] sat24(input logic signed [`SARC_ACC_W-1:0] a);
    if (a > $signed(27'h07F_FFFF)) sat24 = 24'h7F_FFFF;
    else if (a < $signed(27'h780_0000)) sat24 = 24'h80_0000;
    else sat24 = a[OW-1:0];
  endfunction : sat24

  logic [6:0]              os1_r;
  logic [6:0]              os2_r;
  logic [2:0]              os3_r;
  logic [2:0]              ts_r;
  logic [4:0]              len_r;
  logic [15:0]             pend_l_r;
  logic signed [15:0]      hl_r [0:2];
  logic signed [15:0]      hr_r [0:2];
  logic [PER_W-1:0]        el_r;
  logic [PER_W-1:0]        oc_r;
  logic [PER_W+3:0]        ipf_r;
  logic [PER_W+3:0]        opf_r;
  logic [26:0]             set_r;
  logic                    lock_r;
  logic                    fast_q_r;
  logic [3:0]              bl_r;
  sarc_state_t             st_r;
  logic [4:0]              it_r;
  logic [PER_W:0]          rem_r;
  logic [FW:0]             q_r;
  logic signed [26:0]      acl_r;
  logic signed [26:0]      acr_r;
  sarc_frame_t             res_r;
  sarc_frame_t             txf_r;
  logic                    tx_lr_r;
  logic                    tx_wc_r;
  logic [5:0]              tx_pos_r;
  logic                    od_r;
  logic [31:0]             rd_r;
  logic                    ack_r;
  sarc_word_t              rx_word;
  logic                    rx_tog;

  sarc_serial_rx u_rx (
    .bit_clk   (IN_BIT_CLK),
    .rst_n     (RST_N),
    .ce        (CE),
    .word_len  (len_r),
    .frame_clk (IN_FRAME_CLK),
    .word_clk  (IN_WORD_CLK),
    .sdata     (IN_DATA),
    .cfg       (sarc_port_cfg_t'({IN_MODE, IN_RISE})),
    .word      (rx_word),
    .word_tog  (rx_tog)
  );

  // synchronised pins and events
  wire logic           obc      = os2_r[6];
  wire logic           ofc      = os2_r[5];
  wire logic           owc      = os2_r[4];
  wire sarc_port_cfg_t ocfg     = sarc_port_cfg_t'(os2_r[3:1]);
  wire logic           fast     = os2_r[0];
  wire logic           obc_act  = ocfg.rise ? (obc & ~os3_r[2]) : (~obc & os3_r[2]);
  wire logic           ofr_rise = ofc & ~os3_r[1];
  wire logic           in_new   = ts_r[2] ^ ts_r[1];
  wire logic           in_pair  = in_new & ~rx_word.left;

  // ratio tracking
  wire logic [PER_W-1:0] ipf_w   = ipf_r[PER_W+3:4];
  wire logic [PER_W-1:0] opf_w   = opf_r[PER_W+3:4];
  wire logic             down    = opf_w > ipf_w;
  wire logic             in_far  = in_pair && far_off(el_r, ipf_r);
  wire logic             out_far = ofr_rise && far_off(oc_r, opf_r);
  wire logic [26:0]      lim     = fast ? 27'(FAST_SETTLE_CYC) : 27'(SLOW_SETTLE_CYC);
  wire logic             resettle = in_far | out_far | (fast != fast_q_r);
  wire logic             el_big  = (el_r >= ipf_w);

  // coefficient kernel from fraction and blend
  wire logic signed [22:0] p_s  = $signed({2'b00, q_r});
  wire logic signed [27:0] pa   = p_s * $signed({1'b0, bl_r});
  wire logic signed [27:0] ha   = (p_s - 23'sd524288) * $signed({1'b0, bl_r});
  wire sarc_coef_t         c0   = sarc_coef_t'(p_s - (pa >>> 4));
  wire sarc_coef_t         c1   = sarc_coef_t'((23'(ONE) - p_s) + (ha >>> 3));
  wire sarc_coef_t         c2   = ONE - c0 - c1;
  wire sarc_coef_t         csel = (it_r == 5'h00) ? c0 : ((it_r == 5'h01) ? c1 : c2);
  wire logic [PER_W:0]     rem2 = {rem_r[PER_W-1:0], 1'b0};
  wire logic               ge   = rem2 >= {1'b0, ipf_w};

  // serial output
  wire logic       tx_rst  = (ocfg.fmt == SARC_WCLK) ? (owc & ~tx_wc_r) : (ofc ^ tx_lr_r);
  wire logic [5:0] tx_pnxt = tx_rst ? 6'h00 : ((tx_pos_r == 6'h3F) ? tx_pos_r : tx_pos_r + 6'h01);
  wire logic [5:0] tx_st   = sarc_start(ocfg.fmt);
  wire logic [5:0] tx_k    = tx_pnxt - tx_st;
  wire logic       tx_in   = (tx_pnxt >= tx_st) && (tx_k < 6'(OW));
  wire logic [OW-1:0] tx_word = ofc ? (ofr_rise ? res_r.left : txf_r.left) : txf_r.right;
  wire logic       od_nxt  = tx_in ? tx_word[5'(OW - 1) - tx_k[4:0]] : 1'b0;

  // register bus
  wire logic        wb_req = WB_CYC_I & WB_STB_I & ~ack_r;
  wire logic        wr_len = wb_req & WB_WE_I & WB_SEL_I[0] & (WB_ADR_I == `SARC_ADR_CTRL);
  wire logic [31:0] stat   = 32'({bl_r, 2'b00, down, lock_r});
  wire logic [31:0] rd_nxt = (WB_ADR_I == `SARC_ADR_CTRL) ? {27'h000_0000, len_r} :
                             (WB_ADR_I == `SARC_ADR_STAT) ? stat :
                             (WB_ADR_I == `SARC_ADR_IPER) ? 32'(ipf_w) :
                             (WB_ADR_I == `SARC_ADR_OPER) ? 32'(opf_w) : 32'h0000_0000;

  always_ff @(posedge CLK) begin
    if (CE) begin
      os1_r <= {OUT_BIT_CLK, OUT_FRAME_CLK, OUT_WORD_CLK, OUT_MODE, OUT_RISE, SETTLE_FAST};
      os2_r <= os1_r;
      os3_r <= os2_r[6:4];
      ts_r  <= {ts_r[1:0], rx_tog};
    end
  end

  // bus slave and tracking
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ack_r    <= 1'b0;
      rd_r     <= 32'h0000_0000;
      len_r    <= `SARC_CTRL_LEN_RST;
      el_r     <= '0;
      oc_r     <= '0;
      ipf_r    <= '0;
      opf_r    <= '0;
      set_r    <= 27'h000_0000;
      lock_r   <= 1'b0;
      fast_q_r <= 1'b0;
      bl_r     <= 4'h0;
      pend_l_r <= 16'h0000;
    end else if (CE) begin
      ack_r    <= wb_req;
      fast_q_r <= fast;
      if (wb_req && !WB_WE_I) rd_r <= rd_nxt;
      if (wr_len) len_r <= WB_DAT_I[4:0];
      el_r <= in_pair ? '0 : ((&el_r) ? el_r : el_r + 1'b1);
      oc_r <= ofr_rise ? '0 : ((&oc_r) ? oc_r : oc_r + 1'b1);
      if (in_pair) ipf_r <= in_far ? {el_r, 4'h0} : iir_step(ipf_r, el_r, fast);
      if (ofr_rise) opf_r <= out_far ? {oc_r, 4'h0} : iir_step(opf_r, oc_r, fast);
      set_r  <= resettle ? 27'h000_0000 : ((set_r == lim) ? set_r : set_r + 27'h000_0001);
      lock_r <= ~resettle & (set_r == lim);
      if (ofr_rise && down && bl_r != `SARC_BLEND_MAX) bl_r <= bl_r + 4'h1;
      else if (ofr_rise && !down && bl_r != 4'h0) bl_r <= bl_r - 4'h1;
      if (in_new && rx_word.left) pend_l_r <= rx_word.data;
    end
  end

  // history of stereo input samples, newest at index 0
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      for (int i = 0; i < 3; i++) begin
        hl_r[i] <= 16'sh0000;
        hr_r[i] <= 16'sh0000;
      end
    end else if (CE && in_pair) begin
      for (int i = 2; i > 0; i--) begin
        hl_r[i] <= hl_r[i-1];
        hr_r[i] <= hr_r[i-1];
      end
      hl_r[0] <= $signed(pend_l_r);
      hr_r[0] <= $signed(rx_word.data);
    end
  end

  // conversion engine: fraction by division, then three-tap convolution
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      st_r  <= ST_IDLE;
      it_r  <= 5'h00;
      rem_r <= '0;
      q_r   <= '0;
      acl_r <= 27'sh000_0000;
      acr_r <= 27'sh000_0000;
      res_r <= '0;
    end else if (CE) begin
      case (st_r)
        ST_IDLE: begin
          if (ofr_rise) begin
            it_r  <= 5'h00;
            rem_r <= {1'b0, el_r};
            q_r   <= el_big ? {1'b1, 20'h0_0000} : '0;
            st_r  <= el_big ? ST_MAC : ST_DIV;
            acl_r <= 27'sh000_0000;
            acr_r <= 27'sh000_0000;
          end
        end
        ST_DIV: begin
          rem_r <= ge ? rem2 - {1'b0, ipf_w} : rem2;
          q_r   <= {q_r[FW-1:0], ge};
          it_r  <= (it_r == 5'(FW - 1)) ? 5'h00 : it_r + 5'h01;
          if (it_r == 5'(FW - 1)) st_r <= ST_MAC;
        end
        ST_MAC: begin
          acl_r <= acl_r + mac_term(hl_r[it_r[1:0]], csel);
          acr_r <= acr_r + mac_term(hr_r[it_r[1:0]], csel);
          it_r  <= it_r + 5'h01;
          if (it_r == 5'h02) st_r <= ST_DONE;
        end
        ST_DONE: begin
          res_r <= '{left: sat24(acl_r), right: sat24(acr_r)};
          st_r  <= ST_IDLE;
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // output shifter; each frame sends the previous conversion
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      txf_r    <= '0;
      tx_lr_r  <= 1'b0;
      tx_wc_r  <= 1'b0;
      tx_pos_r <= 6'h3F;
      od_r     <= 1'b0;
    end else if (CE) begin
      if (ofr_rise) txf_r <= res_r;
      if (obc_act) begin
        tx_lr_r  <= ofc;
        tx_wc_r  <= owc;
        tx_pos_r <= tx_pnxt;
        od_r     <= od_nxt;
      end
    end
  end

  assign WB_DAT_O = rd_r;
  assign WB_ACK_O = ack_r;
  assign OUT_DATA = od_r;

  default clocking cb_core @(posedge CLK); endclocking
  default disable iff (!RST_N || !CE);

  sequence s_start;
    (st_r == ST_IDLE) && ofr_rise ##1 (st_r != ST_IDLE);
  endsequence
  sequence s_finish;
    ##[1:24] (st_r == ST_DONE) ##1 (st_r == ST_IDLE);
  endsequence
  property p_conv;
    s_start |-> s_finish;
  endproperty
  a_conv: assert property (p_conv) else $error("conversion did not finish in time");

  property p_div;
    ((st_r == ST_DIV) && $past(st_r) == ST_IDLE) |-> ##19 (st_r == ST_DIV) ##1 (st_r == ST_MAC);
  endproperty
  a_div: assert property (p_div) else $error("fraction division length wrong");

  property p_gain;
    ((st_r == ST_DONE) && hl_r[0] == hl_r[1] && hl_r[1] == hl_r[2]) |=>
      ($signed(res_r.left) - $signed({$past(hl_r[0]), 8'h00}) <= 2 &&
       $signed({$past(hl_r[0]), 8'h00}) - $signed(res_r.left) <= 2);
  endproperty
  a_gain: assert property (p_gain) else $error("converter gain is not one");

  property p_blend_up;
    (ofr_rise && down && bl_r < `SARC_BLEND_MAX) |=> (bl_r == $past(bl_r) + 4'h1);
  endproperty
  a_blend_up: assert property (p_blend_up) else $error("cutoff did not step down");

  property p_blend_dn;
    (ofr_rise && !down && bl_r != 4'h0) |=> (bl_r == $past(bl_r) - 4'h1);
  endproperty
  a_blend_dn: assert property (p_blend_dn) else $error("bandwidth not restored");

  property p_lock;
    $rose(lock_r) |-> ($past(set_r) == $past(lim));
  endproperty
  a_lock: assert property (p_lock) else $error("lock before settle time");

  property p_pair;
    in_pair |=> (el_r == '0) && (hl_r[0] == $signed($past(pend_l_r)));
  endproperty
  a_pair: assert property (p_pair) else $error("input pair not stored");

  property p_tx_msb;
    (obc_act && tx_in && tx_k == 6'h00) |=> (OUT_DATA == $past(tx_word[OW-1]));
  endproperty
  a_tx_msb: assert property (p_tx_msb) else $error("output msb misplaced");

  property p_tx_rj;
    (obc_act && ocfg.fmt == SARC_RJ && tx_pnxt < 6'(`SARC_RJ_START)) |=> !OUT_DATA;
  endproperty
  a_tx_rj: assert property (p_tx_rj) else $error("right justified data early");

  property p_tx_len;
    (obc_act && tx_pnxt >= tx_st + 6'(OW)) |=> !OUT_DATA;
  endproperty
  a_tx_len: assert property (p_tx_len) else $error("output word longer than 24");
endmodule : sarc_rate_converter

//--- sarc_link_model.sv
/*
  Far end of both serial ports: a source that sends stereo words and a sink
  that takes the left output word. Assumes mode 0 with falling-edge sampling.
*/
`timescale 1ns/1ps
module sarc_link_model (
  // shared bit and frame clocks, serial lines
  output logic              bclk,
  output logic              lrclk,
  output logic              sdata,
  input  wire logic         out_data,
  // stimulus and capture
  input  wire logic         run,
  input  wire logic [4:0]   len,
  input  wire logic [15:0]  lval,
  input  wire logic [15:0]  rval,
  output logic      [23:0]  cap_l
);
  int          s;
  int          n = 0;
  logic [23:0] sh;
  initial begin
    bclk = 1'b0;
    lrclk = 1'b0;
    sdata = 1'b0;
    cap_l = 24'h000000;
    forever begin
      wait (run);
      // bit clock runs only within frames; launch on the rising edge
      for (s = 0; s < 64; s++) begin
        bclk = 1'b1;
        lrclk = (s < 32);
        sdata = (s % 32 < len) ? (s < 32 ? lval[15 - s % 32] : rval[15 - s % 32]) : ~sdata;
        #32 bclk = 1'b0;
        #32;
      end
    end
  end
  // output changes after the falling edge, so each falling edge sees the previous slot
  always @(negedge bclk) begin
    if (lrclk) begin
      sh = {sh[22:0], out_data};
      if (n == 24) cap_l = sh;
      n = n + 1;
    end else n = 0;
  end
endmodule : sarc_link_model

//--- tb.sv
/*
  Testbench of the rate converter: register rows, reset values, then
  streaming with full and short words. Assumes the link model on both ports.
*/
`timescale 1ns/1ps
module tb;
  logic        CLK = 1'b0, RST_N = 1'b0, ce = 1'b1, fast = 1'b0, rise = 1'b0, wclk = 1'b0;
  logic [1:0]  mode = 2'h0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0, q, rdat;
  logic [3:0]  sel = 4'h0;
  logic        we = 1'b0, cyc = 1'b0, stb = 1'b0, ack, run = 1'b0, bclk, lrclk, sdata, odata;
  logic [4:0]  len = 5'h10;
  logic [15:0] lval = 16'h4000;
  logic [23:0] cap_l;
  int          failures = 0, cmp_count = 0, i;
  logic [71:0] rows [5] = '{{8'h00, 32'h8, 32'h8}, {8'h00, 32'h2, 32'h2}, {8'h00, 32'h1F, 32'h1F},
                            {8'h00, 32'h4, 32'h4}, {8'h10, 32'hFFFF, 32'h0}};
  always #5 CLK = ~CLK;
  sarc_rate_converter #(.SLOW_SETTLE_CYC(200), .FAST_SETTLE_CYC(50)) uut (.CLK(CLK), .RST_N(RST_N), .CE(ce),
    .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_SEL_I(sel), .WB_WE_I(we), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_ACK_O(ack), .IN_BIT_CLK(bclk), .IN_FRAME_CLK(lrclk), .IN_WORD_CLK(wclk),
    .IN_DATA(sdata), .IN_MODE(mode), .IN_RISE(rise), .OUT_BIT_CLK(bclk), .OUT_FRAME_CLK(lrclk),
    .OUT_WORD_CLK(wclk), .OUT_MODE(mode), .OUT_RISE(rise), .OUT_DATA(odata), .SETTLE_FAST(fast));
  sarc_link_model link (.bclk(bclk), .lrclk(lrclk), .sdata(sdata), .out_data(odata), .run(run),
    .len(len), .lval(lval), .rval(16'hC000), .cap_l(cap_l));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input int tol);
    cmp_count++;
    if ((^got) === 1'bx || got > exp + tol || got + tol < exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // classic single cycle; held until ack is sampled high
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge CLK);
    adr <= a; we <= w; wdat <= d; sel <= 4'hF; cyc <= 1'b1; stb <= 1'b1;
    do @(posedge CLK); while (ack !== 1'b1 && ++n < 50);
    if (n >= 50) failures++;
    r = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge CLK);
  endtask : wb
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  initial begin
    #400_000;
    failures++;
    conclude();
  end
  initial begin
    repeat (10) @(posedge CLK);
    chk({31'h0, odata}, 32'h0, 0);
    RST_N <= 1'b1;
    wb(8'h00, 1'b0, 32'h0, q); chk(q, 32'h10, 0);
    for (i = 0; i < 5; i++) begin
      wb(rows[i][71:64], 1'b1, rows[i][63:32], q);
      wb(rows[i][71:64], 1'b0, 32'h0, q); chk(q, rows[i][31:0], 0);
    end
    // second reset with the bit clock running, so the input port leaves reset too
    @(posedge CLK);
    RST_N <= 1'b0;
    run   <= 1'b1;
    repeat (40) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    #1 chk({30'h0, ack, odata}, 32'h0, 0);
    wb(8'h00, 1'b0, 32'h0, q); chk(q, 32'h10, 0);
    wb(8'h00, 1'b1, 32'h10, q);
    repeat (20) @(posedge lrclk);
    chk({8'h00, cap_l}, 32'h400000, 2);
    wb(8'h04, 1'b0, 32'h0, q); chk({30'h0, q[1:0]}, 32'h1, 0);
    wb(8'h08, 1'b0, 32'h0, q); chk(q, 32'd410, 5);
    len  <= 5'h08;
    lval <= 16'h5AFF;
    wb(8'h00, 1'b1, 32'h8, q);
    repeat (20) @(posedge lrclk);
    chk({8'h00, cap_l}, 32'h5A0000, 2);
    conclude();
  end
endmodule : tb
